// File: logic/line_sync.sv
// Two-flop synchroniser with edge detection for the bus lines
`timescale 1ns/1ns
`include "two_wire_map.svh"
module line_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic line_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= line_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign rise_o  = sync & ~prev;
    assign fall_o  = ~sync & prev;
endmodule // line_sync

// File: logic/two_wire_interface.sv
// Two-wire bus protocol engine: master and slave, transmit and receive
`timescale 1ns/1ns
`include "two_wire_map.svh"
module two_wire_interface
    import two_wire_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [6:0]  own_addr_i,
    input  wire logic        broadcast_en_i,
    input  wire logic        slave_ack_en_i,
    input  wire logic [7:0]  slave_tx_data_i,
    input  wire master_cmd_t cmd_i,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    output master_rsp_t      rsp_o,
    output slave_evt_t       evt_o,
    output logic             bus_busy_o
);
    typedef enum {
        M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_A, M_STOP_B, M_WAIT
    } mstate_t;
    typedef enum {S_IDLE, S_ADDR, S_ACK, S_DATA, S_DACK, S_SKIP} sstate_t;

    logic scl_s;
    logic scl_rise;
    logic scl_fall;
    logic sda_s;
    logic sda_rise;
    logic sda_fall;

    line_sync u_scl (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .line_i  (scl_i),
        .level_o (scl_s),
        .rise_o  (scl_rise),
        .fall_o  (scl_fall)
    );
    line_sync u_sda (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .line_i  (sda_i),
        .level_o (sda_s),
        .rise_o  (sda_rise),
        .fall_o  (sda_fall)
    );

    function automatic logic is_reserved(input logic [6:0] a);
        return a[6:3] == `RESERVED_TOP;
    endfunction

    // Conditions on the bus
    logic start_det;
    logic stop_det;
    assign start_det = sda_fall & scl_s;
    assign stop_det  = sda_rise & scl_s;

    logic busy;
    logic next_busy;
    always_comb begin
        next_busy = busy;
        if (start_det)
            next_busy = 1'b1;
        else if (stop_det)
            next_busy = 1'b0;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i)
            busy <= 1'b0;
        else
            busy <= next_busy;
    end
    assign bus_busy_o = busy;

    // ---- Master ----
    mstate_t            ms;
    mstate_t            next_ms;
    logic [`CNT_W-1:0]  mcnt;
    logic [`CNT_W-1:0]  next_mcnt;
    logic [3:0]         mbit;
    logic [3:0]         next_mbit;
    logic [7:0]         msh;
    logic [7:0]         next_msh;
    logic               maddr;
    logic               next_maddr;
    master_cmd_t        mcmd;
    master_cmd_t        next_mcmd;
    logic               m_sda;
    logic               next_m_sda;
    logic               m_scl;
    logic               next_m_scl;
    master_rsp_t        rsp;
    master_rsp_t        next_rsp;
    logic               owner;
    logic               next_owner;

    logic half_done;
    assign half_done = mcnt >= `CNT_W'(`HALF_CYCLES - 1);

    // Master takes a command when idle and free, or when it owns the bus
    assign cmd_ready_o = (ms == M_IDLE && !busy) || ms == M_WAIT;

    // Bit driven in the current slot: address/data or acknowledge
    logic ack_slot_rx;
    assign ack_slot_rx = !maddr && mcmd.read;

    always_comb begin
        next_ms    = ms;
        next_mcnt  = mcnt + `CNT_W'(1);
        next_mbit  = mbit;
        next_msh   = msh;
        next_maddr = maddr;
        next_mcmd  = mcmd;
        next_m_sda = m_sda;
        next_m_scl = m_scl;
        next_rsp   = rsp;
        next_owner = owner;
        next_rsp.done = 1'b0;
        case (ms)
            M_IDLE, M_WAIT: begin
                next_mcnt = '0;
                if (cmd_valid_i && cmd_ready_o) begin
                    next_mcmd     = cmd_i;
                    next_rsp.lost = 1'b0;
                    if (cmd_i.start) begin
                        // Release clock high first for a repeated start
                        next_ms    = M_START;
                        next_m_sda = 1'b1;
                        next_m_scl = 1'b1;
                        next_maddr = 1'b1;
                        next_msh   = {cmd_i.addr, cmd_i.read};
                    end else if (cmd_i.stop && !cmd_i.last) begin
                        next_ms = M_STOP_A;
                    end else begin
                        next_ms    = M_LOW;
                        next_maddr = 1'b0;
                        next_msh   = cmd_i.data;
                    end
                    next_mbit = '0;
                end
            end
            M_START: begin
                // Wait for a real high clock before pulling data down
                if (!scl_s)
                    next_mcnt = '0;
                else if (half_done && m_sda) begin
                    next_m_sda = 1'b0;
                    next_mcnt  = '0;
                    next_owner = 1'b1;
                end else if (half_done) begin
                    next_m_scl = 1'b0;
                    next_ms    = M_LOW;
                    next_mcnt  = '0;
                end
            end
            M_LOW: begin
                if (scl_s)
                    next_mcnt = '0;
                if (mcnt == `CNT_W'(1)) begin
                    // Data changes only in the low phase
                    if (mbit == `BIT_LAST)
                        next_m_sda = maddr ? 1'b1 :
                                     (mcmd.read ? mcmd.last : 1'b1);
                    else
                        next_m_sda = (ack_slot_rx) ? 1'b1 : msh[7];
                end
                if (half_done) begin
                    next_m_scl = 1'b1;
                    next_ms    = M_HIGH;
                    next_mcnt  = '0;
                end
            end
            M_HIGH: begin
                // Stretched low by a slave: count only once really high
                if (!scl_s)
                    next_mcnt = '0;
                if (scl_rise && mbit != `BIT_LAST) begin
                    next_msh = {msh[6:0], sda_s};
                    if (m_sda && !sda_s && !(maddr ? 1'b0 : mcmd.read)) begin
                        next_m_sda    = 1'b1;
                        next_rsp.lost = 1'b1;
                        next_owner    = 1'b0;
                    end
                end
                if (scl_rise && mbit == `BIT_LAST)
                    next_rsp.ack_seen = !sda_s;
                if (scl_s && half_done) begin
                    next_m_scl = 1'b0;
                    next_mcnt  = '0;
                    next_mbit  = mbit + 4'h1;
                    next_ms    = M_LOW;
                    if (rsp.lost && mbit != `BIT_LAST) begin
                        next_ms    = M_IDLE;
                        next_m_scl = 1'b1;
                        next_rsp.done = 1'b1;
                    end else if (mbit == `BIT_LAST) begin
                        next_rsp.done = 1'b1;
                        next_rsp.data = msh;
                        next_ms = (mcmd.stop ||
                                   (maddr && !rsp.ack_seen)) ? M_STOP_A :
                                  M_WAIT;
                    end
                end
            end
            M_STOP_A: begin
                // Data low during the low phase, then release clock
                if (mcnt == `CNT_W'(1))
                    next_m_sda = 1'b0;
                if (half_done) begin
                    next_m_scl = 1'b1;
                    next_ms    = M_STOP_B;
                    next_mcnt  = '0;
                end
            end
            M_STOP_B: begin
                if (!scl_s)
                    next_mcnt = '0;
                else if (half_done) begin
                    next_m_sda = 1'b1;
                    next_owner = 1'b0;
                    next_ms    = M_IDLE;
                end
            end
            default: next_ms = M_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms    <= M_IDLE;
            mcnt  <= '0;
            mbit  <= '0;
            msh   <= '0;
            maddr <= 1'b0;
            mcmd  <= '0;
            m_sda <= 1'b1;
            m_scl <= 1'b1;
            rsp   <= '0;
            owner <= 1'b0;
        end else begin
            ms    <= next_ms;
            mcnt  <= next_mcnt;
            mbit  <= next_mbit;
            msh   <= next_msh;
            maddr <= next_maddr;
            mcmd  <= next_mcmd;
            m_sda <= next_m_sda;
            m_scl <= next_m_scl;
            rsp   <= next_rsp;
            owner <= next_owner;
        end
    end
    assign rsp_o = rsp;

    // ---- Slave ----
    sstate_t    ss;
    sstate_t    next_ss;
    logic [3:0] sbit;
    logic [3:0] next_sbit;
    logic [7:0] ssh;
    logic [7:0] next_ssh;
    logic       s_sda;
    logic       next_s_sda;
    logic       srd;
    logic       next_srd;
    slave_evt_t evt;
    slave_evt_t next_evt;

    logic [6:0] rx_addr;
    logic       own_hit;
    logic       bc_hit;
    assign rx_addr = ssh[7:1];
    assign own_hit = rx_addr == own_addr_i && !is_reserved(own_addr_i);
    assign bc_hit  = broadcast_en_i && rx_addr == `BROADCAST_ADDR
                     && !ssh[0];

    always_comb begin
        next_ss    = ss;
        next_sbit  = sbit;
        next_ssh   = ssh;
        next_s_sda = s_sda;
        next_srd   = srd;
        next_evt   = evt;
        next_evt.addressed  = 1'b0;
        next_evt.byte_valid = 1'b0;
        next_evt.stopped    = 1'b0;
        if (start_det && !owner) begin
            next_ss    = S_ADDR;
            next_sbit  = '0;
            next_s_sda = 1'b1;
        end else if (stop_det) begin
            next_ss          = S_IDLE;
            next_s_sda       = 1'b1;
            next_evt.stopped = ss != S_IDLE && ss != S_SKIP;
        end else begin
            case (ss)
                S_IDLE, S_SKIP: next_s_sda = 1'b1;
                S_ADDR, S_DATA: begin
                    if (scl_rise && !(ss == S_DATA && srd)) begin
                        next_ssh  = {ssh[6:0], sda_s};
                        next_sbit = sbit + 4'h1;
                    end
                    if (scl_rise && ss == S_DATA && srd)
                        next_sbit = sbit + 4'h1;
                    if (scl_fall && ss == S_DATA && srd) begin
                        next_s_sda = ssh[7];
                        next_ssh   = {ssh[6:0], 1'b1};
                    end
                    if (scl_fall && sbit == `BIT_LAST) begin
                        next_sbit = '0;
                        if (ss == S_ADDR) begin
                            if ((own_hit || bc_hit) && slave_ack_en_i) begin
                                next_s_sda         = 1'b0;
                                next_srd           = ssh[0];
                                next_evt.addressed = 1'b1;
                                next_evt.broadcast = bc_hit;
                                next_evt.read      = ssh[0];
                                next_ss            = S_ACK;
                            end else begin
                                next_ss = S_SKIP;
                            end
                        end else begin
                            next_s_sda = srd ? 1'b1 : !slave_ack_en_i;
                            next_evt.data       = ssh;
                            next_evt.byte_valid = !srd;
                            next_ss             = S_DACK;
                        end
                    end
                end
                S_ACK, S_DACK: begin
                    if (scl_rise && ss == S_DACK && srd && sda_s)
                        next_ss = S_SKIP;
                    else if (scl_fall) begin
                        next_ss    = S_DATA;
                        next_ssh   = srd ? slave_tx_data_i : ssh;
                        next_s_sda = srd ? slave_tx_data_i[7] : 1'b1;
                        if (srd)
                            next_ssh = {slave_tx_data_i[6:0], 1'b1};
                        if (!srd && !slave_ack_en_i && ss == S_DACK)
                            next_ss = S_SKIP;
                    end
                end
                default: next_ss = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ss    <= S_IDLE;
            sbit  <= '0;
            ssh   <= '0;
            s_sda <= 1'b1;
            srd   <= 1'b0;
            evt   <= '0;
        end else begin
            ss    <= next_ss;
            sbit  <= next_sbit;
            ssh   <= next_ssh;
            s_sda <= next_s_sda;
            srd   <= next_srd;
            evt   <= next_evt;
        end
    end
    assign evt_o = evt;

    // Open drain: only ever drive low; enable low means driving
    assign sda_o    = 1'b0;
    assign scl_o    = 1'b0;
    assign sda_oe_o = m_sda & s_sda;
    assign scl_oe_o = m_scl;
endmodule // two_wire_interface

// File: shared/two_wire_map.svh
// Constants and operation summary for the two-wire protocol engine
// Operation
// - Pins only pull low or release; the line is a wired-AND.
// - One clock pulse per bit; data stable while the clock is high.
// - Start and stop are data changes while the clock is high.
// - Bus busy from start to stop; master waits while busy.
// - Repeated start keeps the bus busy until the next stop.
// - Address packet: seven address bits, direction bit, acknowledge.
// - Direction one means read, zero means write.
// - Addressed slave pulls data low in ninth cycle, else releases.
// - After an address not acknowledged, master stops or restarts; this master always stops.
// - Address and data bytes go most significant bit first.
// - All-zero address is broadcast; enabled slaves acknowledge writes.
// - Addresses with upper four bits all ones are reserved.
// - Data packet: eight data bits then one acknowledge bit.
// - Receiver acknowledges with low in ninth cycle; high is refusal.
// - Receiver answers its final byte with a not-acknowledge.
// - Only the master makes clock pulses, start and stop.
// - Transfer is start, address, data packets, stop; no empty one.
// - Slave may hold clock low; master waits for a real rise.
// - Stretching affects only the low phase; master sets high phase.
// - Seven-bit own address, programmable, optional broadcast match.
// - Works up to 400 kHz as master and slave.
// - Master reading low after driving high loses arbitration.
// - Master times its phases from real line transitions.
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH
`define CLK_FREQ_KHZ      100000
`define BUS_FREQ_KHZ      400
// Half bit period in system clocks, rounded down, so never longer than half the bus period
`define HALF_CYCLES       (`CLK_FREQ_KHZ / (2 * `BUS_FREQ_KHZ))
`define BROADCAST_ADDR    7'h00
`define RESERVED_TOP      4'hF
`define BIT_LAST          4'h8
`define CNT_W             8
`endif

// File: shared/two_wire_pkg.sv
// Types shared by the two-wire protocol engine
package two_wire_pkg;
    typedef struct packed {
        logic       start;
        logic [6:0] addr;
        logic       read;
        logic [7:0] data;
        logic       last;
        logic       stop;
    } master_cmd_t;

    typedef struct packed {
        logic       done;
        logic       ack_seen;
        logic       lost;
        logic [7:0] data;
    } master_rsp_t;

    typedef struct packed {
        logic       addressed;
        logic       broadcast;
        logic       read;
        logic       byte_valid;
        logic [7:0] data;
        logic       stopped;
    } slave_evt_t;
endpackage

// File: verification/bus_slave_model.sv
// Behavioural far-side slave with clock stretching at byte boundaries
`timescale 1ns/1ns
module bus_slave_model #(
    parameter logic [6:0] ADDR = 7'h51
) (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       ack_en_i,
    input  wire logic [7:0] tx_i,
    input  wire logic [7:0] stretch_i,
    output logic            scl_oe_o,
    output logic            sda_oe_o,
    output logic [7:0]      rx_o
);
    logic       on;
    logic       sel;
    logic       rd;
    logic       addr_ph;
    logic [3:0] bit_no;
    logic [7:0] sh;
    logic [7:0] tx;

    // Outputs start released; the pull-up makes a released line high
    initial begin
        {on, sel, rd, addr_ph, bit_no, sh, tx, rx_o} = '0;
        scl_oe_o = 1'b1;
        sda_oe_o = 1'b1;
    end
    // The clock fall that closes the start wraps the count to bit zero
    always @(negedge sda_i) if (scl_i) begin
        {on, sel, addr_ph, bit_no} = {3'b101, 4'hF};
        sda_oe_o = 1'b1;
    end
    always @(posedge sda_i) if (scl_i) begin
        {on, sel} = 2'b00;
        sda_oe_o = 1'b1;
    end
    always @(posedge scl_i) if (on) begin
        if (bit_no < 8) sh = {sh[6:0], sda_i};
        else if (sel && rd && !addr_ph && sda_i) sel = 1'b0;
    end
    always @(negedge scl_i) if (on) begin
        bit_no = bit_no + 4'h1;
        if (bit_no == 8) begin
            if (addr_ph) begin
                sel = (sh[7:1] == ADDR);
                rd = sh[0];
            end else if (sel && !rd) rx_o = sh;
            sda_oe_o = !(sel && (addr_ph || (!rd && ack_en_i)));
        end else if (bit_no == 9) begin
            {bit_no, addr_ph} = 5'h00;
            sda_oe_o = 1'b1;
            if (sel && rd) tx = tx_i;
        end
        if (sel && rd && !addr_ph && bit_no < 8) begin
            sda_oe_o = tx[3'd7 - bit_no[2:0]];
        end
        // Only the low phase is lengthened; the master owns the high phase
        if (sel && bit_no == 0 && stretch_i != 0) begin
            scl_oe_o = 1'b0;
            #(stretch_i * 10);
            scl_oe_o = 1'b1;
        end
    end
endmodule // bus_slave_model

// File: verification/test_two_wire_interface.sv
// Self-checking bench for the two-wire protocol engine
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module test_two_wire_interface;
    import two_wire_pkg::*;
    localparam logic [6:0] PART = 7'h51;
    logic        clk_i, rst_i, scl_i, sda_i, scl_o, sda_o, scl_oe_o, sda_oe_o;
    logic        broadcast_en_i, slave_ack_en_i, cmd_valid_i, cmd_ready_o;
    logic        bus_busy_o, m_scl, m_sda, p_scl, p_sda, p_ack;
    logic [6:0]  own_addr_i;
    logic [7:0]  slave_tx_data_i, p_tx, p_str, p_rx, ev_dt;
    master_cmd_t cmd_i;
    master_rsp_t rsp_o;
    slave_evt_t  evt_o;
    logic        ev_bc;
    int          ev_n, fail_count, checked;

    assign scl_i = (scl_oe_o | scl_o) & p_scl & m_scl;
    assign sda_i = (sda_oe_o | sda_o) & p_sda & m_sda;

    two_wire_interface two_wire_interface_inst (.clk_i, .rst_i, .scl_i,
        .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .own_addr_i,
        .broadcast_en_i, .slave_ack_en_i, .slave_tx_data_i, .cmd_i,
        .cmd_valid_i, .cmd_ready_o, .rsp_o, .evt_o, .bus_busy_o);
    bus_slave_model #(.ADDR(PART)) bus_slave_model_inst (.scl_i(scl_i),
        .sda_i(sda_i), .ack_en_i(p_ack), .tx_i(p_tx), .stretch_i(p_str),
        .scl_oe_o(p_scl), .sda_oe_o(p_sda), .rx_o(p_rx));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (evt_o.addressed) begin
            ev_n <= ev_n + 1;
            ev_bc <= evt_o.broadcast;
        end
        if (evt_o.byte_valid) ev_dt <= evt_o.data;
    end

    task automatic stop_test;
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic exp_ack(input logic [6:0] a, input logic r);
        if (!slave_ack_en_i) return 1'b1;
        if (a == 7'h00) return !(broadcast_en_i && !r);
        return !(a == own_addr_i && own_addr_i[6:3] != 4'hF);
    endfunction

    task automatic mcmd(input logic s, input logic [6:0] a, input logic r,
                        input logic [7:0] d, input logic l, input logic p);
        int n;
        @(posedge clk_i);
        #1 cmd_i = '{s, a, r, d, l, p};
        cmd_valid_i = 1'b1;
        for (n = 0; !cmd_ready_o && n < 9000; n++) @(negedge clk_i);
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b0;
        for (n = 0; n < 9000; n++) begin
            @(posedge clk_i);
            #1 if (rsp_o.done === 1'b1 || (p && bus_busy_o === 1'b0)) break;
        end
        if (n == 9000) fail_count++;
    endtask

    task automatic wait_free;
        for (int n = 0; bus_busy_o !== 1'b0 && n < 3000; n++) @(posedge clk_i);
        `CHK(bus_busy_o, 1'b0)
    endtask

    // Link clock master at an 80 ns bit period, data moved 10 ns into the 40 ns low phase
    task automatic mbits(input logic [8:0] v, output logic [8:0] g);
        for (int i = 8; i >= 0; i--) begin
            #10 m_sda = v[i];
            #30 m_scl = 1'b1;
            #30 g[i] = sda_i;
            #10 m_scl = 1'b0;
        end
    endtask

    task automatic sl_case(input logic [6:0] a, input logic r);
        logic [8:0] g;
        logic [7:0] d;
        logic       x;
        int         e;
        d = 8'($urandom);
        e = ev_n;
        x = exp_ack(a, r);
        #40 m_sda = 1'b0;
        #40 m_scl = 1'b0;
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b1;
        mbits({a, r, 1'b1}, g);
        `CHK(g[0], x)
        `CHK(cmd_ready_o, 1'b0)
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b0;
        if (!x && !r) begin
            mbits({d, 1'b1}, g);
            `CHK(g[0], 1'b0)
            `CHK(ev_dt, d)
            `CHK(ev_bc, (a == 7'h00))
        end
        if (!x && r) begin
            mbits(9'h1FF, g);  // Final byte refused to end the read
            `CHK(g[8:1], slave_tx_data_i)
        end
        `CHK(ev_n - e, int'(!x))
        #10 m_sda = 1'b0;
        #30 m_scl = 1'b1;
        #40 m_sda = 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK(bus_busy_o, 1'b0)
        #1;
    endtask

    initial begin
        #1000000;
        fail_count++;
        stop_test;
    end

    initial begin
        logic [7:0] d;
        void'($urandom(88322));
        {clk_i, rst_i, m_scl, m_sda, p_ack, cmd_valid_i} = 6'b011110;
        {broadcast_en_i, slave_ack_en_i, p_str, ev_n} = '0;
        {slave_tx_data_i, p_tx, d, ev_dt, ev_bc} = '0;
        {fail_count, checked} = '0;
        own_addr_i = 7'h01;
        cmd_i = '{1'b1, PART, 1'b0, 8'h00, 1'b0, 1'b0};
        repeat (6) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (5) @(posedge clk_i);
        // Design as master: write two bytes, clock stretched after the second one, before the stop
        mcmd(1, PART, 0, 0, 0, 0);
        `CHK(rsp_o.ack_seen, 1'b1)
        d = 8'($urandom);
        mcmd(0, PART, 0, d, 0, 0);
        `CHK(p_rx, d)
        p_str = 8'd20 + 8'($urandom % 180);
        d = 8'($urandom);
        mcmd(0, PART, 0, d, 1, 1);
        `CHK(p_rx, d)
        wait_free;
        p_str = 8'h00;
        p_tx = 8'($urandom);
        mcmd(1, PART, 1, 0, 0, 0);
        mcmd(0, PART, 1, 0, 1, 1);
        `CHK(rsp_o.data, p_tx)
        wait_free;
        // Unanswered address, then a stop and a fresh start on the free bus
        mcmd(1, 7'h23, 0, 0, 0, 0);
        `CHK(rsp_o.ack_seen, 1'b0)
        mcmd(1, PART, 0, 0, 0, 0);
        `CHK(rsp_o.ack_seen, 1'b1)
        `CHK(bus_busy_o, 1'b1)
        p_ack = 1'b0;
        mcmd(0, PART, 0, 8'($urandom), 0, 0);
        `CHK(rsp_o.ack_seen, 1'b0)
        mcmd(0, PART, 0, 0, 0, 1);
        wait_free;
        p_ack = 1'b1;
        // Design as slave; broadcast is only ever sent with write
        slave_ack_en_i = 1'b1;
        own_addr_i = 7'h01 + 7'($urandom % 64);
        slave_tx_data_i = 8'($urandom);
        sl_case(own_addr_i, 1'b0);
        sl_case(own_addr_i, 1'b1);
        for (int b = 0; b < 2; b++) begin
            broadcast_en_i = b[0];
            sl_case(7'h00, 1'b0);
        end
        slave_ack_en_i = 1'b0;
        sl_case(own_addr_i, 1'b0);
        slave_ack_en_i = 1'b1;
        own_addr_i = 7'h78 | 7'($urandom % 8);
        sl_case(own_addr_i, 1'b0);
        stop_test;
    end
endmodule // test_two_wire_interface

// File: verification/two_wire_interface_asserts.sv
// Port-level protocol checks for the two-wire protocol engine
`timescale 1ns/1ns
module two_wire_interface_asserts
    import two_wire_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    input  wire logic        scl_o,
    input  wire logic        scl_oe_o,
    input  wire logic        sda_i,
    input  wire logic        sda_o,
    input  wire logic        sda_oe_o,
    input  wire logic [6:0]  own_addr_i,
    input  wire logic        broadcast_en_i,
    input  wire logic        slave_ack_en_i,
    input  wire logic [7:0]  slave_tx_data_i,
    input  wire master_cmd_t cmd_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_ready_o,
    input  wire master_rsp_t rsp_o,
    input  wire slave_evt_t  evt_o,
    input  wire logic        bus_busy_o
);
    localparam int MIN_HIGH = 124;
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;

    // Saturates so an idle bus never wraps back under the limit
    always_comb begin
        next_hi_cnt = 8'h00;
        if (scl_i) begin
            next_hi_cnt = (hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        hi_cnt <= rst_i ? 8'h00 : next_hi_cnt;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence start_seq;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence stop_seq;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence

    AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin output value is not low");
    AST_RESET_IDLE: assert property ($fell(rst_i) |->
        scl_oe_o && sda_oe_o && !bus_busy_o)
        else $error("lines or busy not idle after reset");
    AST_START_BUSY: assert property (start_seq |-> ##[1:6] bus_busy_o)
        else $error("start not followed by busy");
    AST_STOP_FREE: assert property (stop_seq |-> ##[1:6] !bus_busy_o)
        else $error("stop not followed by free bus");
    AST_SDA_HIGH_STABLE: assert property ($fell(sda_oe_o) && scl_i
        && $past(scl_i) |-> ##[1:6] bus_busy_o)
        else $error("data pulled while clock high outside a start");
    AST_HIGH_PHASE: assert property ($fell(scl_oe_o) && hi_cnt != 8'h00
        |-> hi_cnt >= MIN_HIGH)
        else $error("clock high phase cut short");
    AST_DONE_PULSE: assert property (rsp_o.done |=> !rsp_o.done)
        else $error("done longer than one cycle");
    AST_EVT_PULSE: assert property (evt_o.addressed || evt_o.byte_valid
        |=> !evt_o.addressed && !evt_o.byte_valid)
        else $error("slave event longer than one cycle");
    AST_BROADCAST_WRITE: assert property (evt_o.addressed && evt_o.broadcast
        |-> !evt_o.read && broadcast_en_i)
        else $error("broadcast accepted when not allowed");
    AST_ADDR_BUSY: assert property (evt_o.addressed |-> bus_busy_o)
        else $error("addressed outside a busy bus");
    AST_NO_RESERVED: assert property (evt_o.addressed && !evt_o.broadcast
        |-> own_addr_i[6:3] != 4'hF)
        else $error("reserved address matched");
endmodule // two_wire_interface_asserts

bind two_wire_interface two_wire_interface_asserts
    two_wire_interface_asserts_inst (.*);
